// *** design/wt_defs.svh ***
// Register offsets, field positions, reset values and timing figures of the watch timer.
// Assumes inclusion by bare name from every design file that needs a number.
`ifndef WT_DEFS_SVH
`define WT_DEFS_SVH

// Byte addresses on the register bus
`define WT_ADDR_MODE 32'h0000_0f88
`define WT_ADDR_STAT 32'h0000_0f8c
`define WT_ADDR_MASK 32'h0000_0f90

// Mode register layout
`define WT_MODE_RESET 8'h00
`define WT_BIT_TONE_EN 7
`define WT_BIT_ZERO 6
`define WT_BIT_TONE_HI 5
`define WT_BIT_TONE_LO 4
`define WT_BIT_LEVEL 3
`define WT_BIT_RUN 2
`define WT_BIT_FAST 1
`define WT_BIT_SRC 0

// Status and mask layout
`define WT_BIT_TICK 0
`define WT_STAT_RESET 1'b0

// Timing: watch clock rate and the two intervals in their own units
`define WT_FX_DIV 128
`define WT_FW_HZ 32768
`define WT_NORMAL_MS 500
`define WT_FAST_US10 391
`define WT_TONE_2K_TAP 3

`endif

// *** design/wt_pkg.sv ***
// Types shared by the watch timer modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package wt_pkg;

  // Tone frequency select, in register field order
  typedef enum logic [1:0] {
    WT_TONE_2K,
    WT_TONE_4K,
    WT_TONE_8K,
    WT_TONE_16K
  } wt_tone_t;

endpackage : wt_pkg

`default_nettype wire

// *** design/wt_ctl_if.sv ***
// Control and event bundle between the register side and the divider chain.
// Assumes both ends run on the same clock.
`default_nettype none

interface wt_ctl_if;
  logic run;
  logic src_sub;
  logic fast;
  wt_pkg::wt_tone_t tone_sel;
  logic fw_tick;
  logic watch_event;
  logic tone_wave;

  // Register side drives the mode, divider answers with ticks and the tone
  modport ctl (
    output run, src_sub, fast, tone_sel,
    input fw_tick, watch_event, tone_wave
  );
  modport div (
    input run, src_sub, fast, tone_sel,
    output fw_tick, watch_event, tone_wave
  );
endinterface : wt_ctl_if

`default_nettype wire

// *** design/wt_sync.sv ***
// Two-stage synchroniser for pin levels entering the CLK domain.
// Assumes the inputs are slow against CLK; no reset so a pin level passes even during reset.
`default_nettype none

module wt_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_r <= din;
    sync_r <= meta_r;
  end

  assign dout = sync_r;

endmodule : wt_sync

`default_nettype wire

// *** design/wt_divider.sv ***
// Clock selector, fx prescaler and binary divider chain of the watch timer.
// Assumes one-cycle rising-edge pulses of the synchronised oscillator inputs.
`default_nettype none

`include "wt_defs.svh"

module wt_divider #(
  parameter int FX_DIV = `WT_FX_DIV,
  parameter int NORMAL_TICKS = 16384,
  parameter int FAST_TICKS = 128
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic fx_rise,
  input wire logic fxt_rise,
  wt_ctl_if.div ctl
);

  localparam int PRE_W = (FX_DIV > 2) ? $clog2(FX_DIV) : 1;
  localparam int CHAIN_W = $clog2(NORMAL_TICKS);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(FX_DIV - 1);
  localparam logic [CHAIN_W-1:0] NORMAL_MASK = CHAIN_W'(NORMAL_TICKS - 1);
  localparam logic [CHAIN_W-1:0] FAST_MASK = CHAIN_W'(FAST_TICKS - 1);

  logic [PRE_W-1:0] pre_r;
  logic [CHAIN_W-1:0] chain_r;
  logic fx_div_tick;
  logic [CHAIN_W-1:0] sel_mask;

  //////////////////////////////////////////////////////////////////////////////
  // fx/128 prescaler, held cleared while stopped
  always_ff @(posedge clk) begin
    if (reset || !ctl.run) begin
      pre_r <= '0;
    end else if (fx_rise) begin
      pre_r <= (pre_r == PRE_LAST) ? '0 : pre_r + 1'b1;
    end
  end

  // Source select; both give the same watch rate at nominal crystals
  assign fx_div_tick = fx_rise && (pre_r == PRE_LAST);
  assign ctl.fw_tick = ctl.run && (ctl.src_sub ? fxt_rise : fx_div_tick);

  // One shared binary chain gives interval and tone
  always_ff @(posedge clk) begin
    if (reset || !ctl.run) begin
      chain_r <= '0;
    end else if (ctl.fw_tick) begin
      chain_r <= chain_r + 1'b1;
    end
  end

  // Interval ends when the tapped low bits roll over
  assign sel_mask = ctl.fast ? FAST_MASK : NORMAL_MASK;
  assign ctl.watch_event = ctl.fw_tick && ((chain_r & sel_mask) == sel_mask);

  // Square wave taps: fw/16 down to fw/2
  always_comb begin
    case (ctl.tone_sel)
      wt_pkg::WT_TONE_2K: ctl.tone_wave = chain_r[`WT_TONE_2K_TAP];
      wt_pkg::WT_TONE_4K: ctl.tone_wave = chain_r[`WT_TONE_2K_TAP - 1];
      wt_pkg::WT_TONE_8K: ctl.tone_wave = chain_r[`WT_TONE_2K_TAP - 2];
      wt_pkg::WT_TONE_16K: ctl.tone_wave = chain_r[`WT_TONE_2K_TAP - 3];
      default: ctl.tone_wave = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  a_stop_clears: assert property (@(posedge clk) disable iff (reset)
    !ctl.run |=> (chain_r == '0) && (pre_r == '0))
    else $error("divider not cleared while stopped");
  a_fast_rollover: assert property (@(posedge clk) disable iff (reset)
    (ctl.watch_event && ctl.fast && ctl.run) |=> ((chain_r & FAST_MASK) == '0))
    else $error("fast interval not on a rollover");
  a_normal_rollover: assert property (@(posedge clk) disable iff (reset)
    (ctl.watch_event && !ctl.fast && ctl.run) |=> (chain_r & NORMAL_MASK) == '0)
    else $error("normal interval not on a rollover");
  a_fx_source: assert property (@(posedge clk) disable iff (reset)
    (ctl.fw_tick && !ctl.src_sub) |-> (fx_rise && pre_r == PRE_LAST))
    else $error("main source tick without full prescale");

endmodule : wt_divider

`default_nettype wire

// *** design/wt_watch_timer.sv ***
// Watch timer top: AHB-Lite register slave, mode register, tick flag, tone and display clock.
// Assumes one 25 MHz CLK, synchronous active-high RESET, and oscillator levels on plain pins.
//
// Register access over AHB-Lite was decided locally.
`default_nettype none

`include "wt_defs.svh"

// Overview of operation
// - Fast mode interrupts every 3.91 ms
// - Normal mode interrupts every 0.5 s
// - Mode bit 3 shows sub oscillator level
// - Mode written whole, write-only, bit6 zero
// - Level bit read-only, writes ignore it
// - Reset clears mode, level stays live
// - Bit 7 gates the tone output
// - Bits 5:4 pick 2/4/8/16 kHz
// - Bit 2 runs; zero clears all dividers
// - Bit 0 picks fx/128 or sub oscillator
// - Nominal crystals give equal watch rate
// - Flag set at every elapsed interval
// - Watch timer clocks the display; stops too
module wt_watch_timer #(
  parameter int FX_DIV = `WT_FX_DIV,
  parameter int NORMAL_TICKS = `WT_NORMAL_MS * `WT_FW_HZ / 1000,
  parameter int FAST_TICKS = `WT_FAST_US10 * `WT_FW_HZ / 100000
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic MAIN_OSC_CLOCK,
  input wire logic SUB_OSC_INPUT,
  output logic TONE_OUTPUT,
  output logic DISP_CLOCK_TICK,
  output logic WATCH_IRQ
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  wt_ctl_if ctl_bus ();

  logic [1:0] pins_sync;
  logic fx_lvl;
  logic fxt_lvl;
  logic fx_prev_r;
  logic fxt_prev_r;
  logic fx_rise;
  logic fxt_rise;

  logic ahb_take;
  logic dph_wr_r;
  logic [31:0] dph_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_value;
  logic wr_mode;
  logic wr_stat;
  logic wr_mask;

  logic [7:0] watch_mode_control_r;
  logic [7:0] mode_nxt;
  logic watch_tick_flag_r;
  logic watch_tick_flag_nxt;
  logic tick_mask_r;
  logic tone_r;
  logic disp_r;

  //////////////////////////////////////////////////////////////////////////////
  // Pin inputs: synchronise, then find rising edges on the settled copy

  wt_sync #(
    .W(2)
  ) u_pin_sync (
    .clk(CLK),
    .din({SUB_OSC_INPUT, MAIN_OSC_CLOCK}),
    .dout(pins_sync)
  );

  assign fx_lvl = pins_sync[0];
  assign fxt_lvl = pins_sync[1];

  // Edge history; oscillators must stay well below CLK/2 to be seen
  // Reset preloads the settled level, so a pin idling high gives no false edge
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fx_prev_r <= fx_lvl;
      fxt_prev_r <= fxt_lvl;
    end else begin
      fx_prev_r <= fx_lvl;
      fxt_prev_r <= fxt_lvl;
    end
  end

  assign fx_rise = fx_lvl && !fx_prev_r;
  assign fxt_rise = fxt_lvl && !fxt_prev_r;

  //////////////////////////////////////////////////////////////////////////////
  // Divider chain

  assign ctl_bus.run = watch_mode_control_r[`WT_BIT_RUN];
  assign ctl_bus.src_sub = watch_mode_control_r[`WT_BIT_SRC];
  assign ctl_bus.fast = watch_mode_control_r[`WT_BIT_FAST];
  assign ctl_bus.tone_sel = wt_pkg::wt_tone_t'(
    watch_mode_control_r[`WT_BIT_TONE_HI:`WT_BIT_TONE_LO]);

  wt_divider #(
    .FX_DIV(FX_DIV),
    .NORMAL_TICKS(NORMAL_TICKS),
    .FAST_TICKS(FAST_TICKS)
  ) u_divider (
    .clk(CLK),
    .reset(RESET),
    .fx_rise(fx_rise),
    .fxt_rise(fxt_rise),
    .ctl(ctl_bus)
  );

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  // Only NONSEQ/SEQ with HREADY high start a transfer; HSIZE is not checked
  assign ahb_take = HSEL && HTRANS[1] && HREADY;

  // Address phase capture for the following data phase
  always_ff @(posedge CLK) begin
    if (RESET) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 32'h0000_0000;
    end else begin
      dph_wr_r <= ahb_take && HWRITE;
      if (ahb_take) begin
        dph_addr_r <= HADDR;
      end
    end
  end

  assign wr_mode = dph_wr_r && (dph_addr_r == `WT_ADDR_MODE);
  assign wr_stat = dph_wr_r && (dph_addr_r == `WT_ADDR_STAT);
  assign wr_mask = dph_wr_r && (dph_addr_r == `WT_ADDR_MASK);

  // Read view: mode reads back only the live level bit; unmapped reads zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (HADDR)
      `WT_ADDR_MODE: rd_value[`WT_BIT_LEVEL] = fxt_lvl;
      `WT_ADDR_STAT: rd_value[`WT_BIT_TICK] = watch_tick_flag_r;
      `WT_ADDR_MASK: rd_value[`WT_BIT_TICK] = tick_mask_r;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // Read data sampled at the address phase so it comes from a flop
  always_ff @(posedge CLK) begin
    if (RESET) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ahb_take && !HWRITE) begin
      hrdata_r <= rd_value;
    end else begin
      hrdata_r <= 32'h0000_0000;
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Mode register

  // Whole-byte write; bit 6 forced low and the level bit never stored
  always_comb begin
    mode_nxt = HWDATA[7:0];
    mode_nxt[`WT_BIT_ZERO] = 1'b0;
    mode_nxt[`WT_BIT_LEVEL] = 1'b0;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      watch_mode_control_r <= `WT_MODE_RESET;
    end else if (wr_mode) begin
      watch_mode_control_r <= mode_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tick flag, mask and interrupt

  // Hardware never clears the flag; a new tick beats a same-cycle clear
  always_comb begin
    watch_tick_flag_nxt = watch_tick_flag_r;
    if (wr_stat && HWDATA[`WT_BIT_TICK]) begin
      watch_tick_flag_nxt = 1'b0;
    end
    if (ctl_bus.watch_event) begin
      watch_tick_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      watch_tick_flag_r <= `WT_STAT_RESET;
    end else begin
      watch_tick_flag_r <= watch_tick_flag_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      tick_mask_r <= 1'b0;
    end else if (wr_mask) begin
      tick_mask_r <= HWDATA[`WT_BIT_TICK];
    end
  end

  // Level output straight from two flops, no extra lag
  assign WATCH_IRQ = watch_tick_flag_r && tick_mask_r;

  //////////////////////////////////////////////////////////////////////////////
  // Tone and display clock outputs

  // Tone low when disabled; the port latch and pin mode stay software's job
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tone_r <= 1'b0;
    end else begin
      tone_r <= watch_mode_control_r[`WT_BIT_TONE_EN] && ctl_bus.tone_wave;
    end
  end

  // Display controller gets one pulse per watch clock; none while stopped
  always_ff @(posedge CLK) begin
    if (RESET) begin
      disp_r <= 1'b0;
    end else begin
      disp_r <= ctl_bus.fw_tick;
    end
  end

  assign TONE_OUTPUT = tone_r;
  assign DISP_CLOCK_TICK = disp_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_reset_clears_mode: assert property (@(posedge CLK)
    RESET |=> (watch_mode_control_r == `WT_MODE_RESET) && !watch_tick_flag_r)
    else $error("reset left mode or flag set");
  a_mode_bit_zero: assert property (@(posedge CLK) disable iff (RESET)
    wr_mode |=> !watch_mode_control_r[`WT_BIT_ZERO] &&
      (watch_mode_control_r[`WT_BIT_TONE_EN] == $past(HWDATA[`WT_BIT_TONE_EN])))
    else $error("mode write stored wrongly");
  a_level_not_stored: assert property (@(posedge CLK) disable iff (RESET)
    (wr_mode && HWDATA[`WT_BIT_LEVEL]) |=> !watch_mode_control_r[`WT_BIT_LEVEL])
    else $error("level bit took a write");
  a_level_read_live: assert property (@(posedge CLK) disable iff (RESET)
    (ahb_take && !HWRITE && HADDR == `WT_ADDR_MODE) |=>
      HRDATA == {28'h0000_000, $past(fxt_lvl), 3'h0})
    else $error("mode read not the live level");
  a_flag_sets: assert property (@(posedge CLK) disable iff (RESET)
    ctl_bus.watch_event |=> watch_tick_flag_r ##1 (watch_tick_flag_r || $past(wr_stat)))
    else $error("tick did not set the flag");
  a_flag_holds: assert property (@(posedge CLK) disable iff (RESET)
    (watch_tick_flag_r && !wr_stat) |=> watch_tick_flag_r)
    else $error("flag cleared without software");
  a_tone_gated: assert property (@(posedge CLK) disable iff (RESET)
    !watch_mode_control_r[`WT_BIT_TONE_EN] |=> !TONE_OUTPUT)
    else $error("tone out while disabled");
  a_disp_stops: assert property (@(posedge CLK) disable iff (RESET)
    !watch_mode_control_r[`WT_BIT_RUN] |=> !DISP_CLOCK_TICK)
    else $error("display clock ran while stopped");

  // Flag moves only on a software clear or an elapsed interval; a status read returns the flag
  a_flag_clears: assert property (@(posedge CLK) disable iff (RESET)
    (wr_stat && HWDATA[`WT_BIT_TICK] && !ctl_bus.watch_event) |=> !watch_tick_flag_r)
    else $error("flag not cleared by a write of one");
  a_flag_needs_tick: assert property (@(posedge CLK) disable iff (RESET)
    (!watch_tick_flag_r && !ctl_bus.watch_event) |=> !watch_tick_flag_r)
    else $error("flag set without an elapsed interval");
  a_stat_read: assert property (@(posedge CLK) disable iff (RESET)
    (ahb_take && !HWRITE && HADDR == `WT_ADDR_STAT) |=>
      HRDATA == {31'h0, $past(watch_tick_flag_r)})
    else $error("status read not the flag");

  // Stop, source and display pulse; the tone needs one cycle for the chain to clear
  a_tone_stopped: assert property (@(posedge CLK) disable iff (RESET)
    (!ctl_bus.run ##1 !ctl_bus.run) |=> !TONE_OUTPUT)
    else $error("tone ran while stopped");
  a_sub_source: assert property (@(posedge CLK) disable iff (RESET)
    (ctl_bus.fw_tick && ctl_bus.src_sub) |-> fxt_rise)
    else $error("sub source tick without a pin edge");
  a_disp_follows: assert property (@(posedge CLK) disable iff (RESET)
    ctl_bus.fw_tick |=> DISP_CLOCK_TICK)
    else $error("display pulse missing after a watch tick");

endmodule : wt_watch_timer

`default_nettype wire

// *** tb/wt_osc_model.sv ***
// Model of the main and subsystem oscillator pins that feed the watch timer.
// Assumes the bench clock; oscillators run only while enabled; a stopped main pin holds its level, the sub pin follows sub_level.
`default_nettype none

module wt_osc_model #(
  parameter int MAIN_HALF = 2,
  parameter int SUB_HALF = 4
) (
  input wire logic clk,
  input wire logic main_on,
  input wire logic sub_on,
  input wire logic sub_level,
  output logic main_osc,
  output logic sub_osc
);
  timeunit 1ns;
  timeprecision 1ns;
  int mc = 0;
  int sc = 0;

  initial begin
    main_osc = 1'b0;
    sub_osc = 1'b1;
  end

  // Half periods chosen so main/FX_DIV and sub give one watch rate
  // A stopped crystal keeps its last level; the sub pin then shows the static level
  always @(posedge clk) begin
    if (main_on) begin
      mc = mc + 1;
      if (mc >= MAIN_HALF) begin
        mc = 0;
        main_osc <= ~main_osc;
      end
    end
    if (sub_on) begin
      sc = sc + 1;
      if (sc >= SUB_HALF) begin
        sc = 0;
        sub_osc <= ~sub_osc;
      end
    end else begin
      sub_osc <= sub_level;
    end
  end
endmodule : wt_osc_model

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the watch timer: register reads, interrupt intervals, tone periods.
// Assumes the design header and package are compiled first; pins come from the osc model.
`default_nettype none

`include "wt_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] AU = 32'h0000_0f94;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, MAIN_OSC_CLOCK, SUB_OSC_INPUT, TONE_OUTPUT, DISP_CLOCK_TICK, WATCH_IRQ;
  logic main_on = 1'b0;
  logic sub_on = 1'b0;
  logic lvl = 1'b1;
  logic rd_ph = 1'b0;
  logic snap = 1'b0;
  logic zr = 1'b0;
  logic tw = 1'b0;
  logic irq_q = 1'b0;
  logic tone_q = 1'b0;
  logic [31:0] q[$];
  logic [31:0] rv;
  logic [7:0] tbl[4] = '{8'h05, 8'h07, 8'h04, 8'h06};
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int tcnt = 0;
  int ncnt = 0;
  integer seed = 32'he676;

  wt_watch_timer #(.FX_DIV(2), .NORMAL_TICKS(16), .FAST_TICKS(4)) dut_u (
    .CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .MAIN_OSC_CLOCK(MAIN_OSC_CLOCK), .SUB_OSC_INPUT(SUB_OSC_INPUT),
    .TONE_OUTPUT(TONE_OUTPUT), .DISP_CLOCK_TICK(DISP_CLOCK_TICK), .WATCH_IRQ(WATCH_IRQ));

  wt_osc_model osc_u (
    .clk(CLK), .main_on(main_on), .sub_on(sub_on), .sub_level(lvl),
    .main_osc(MAIN_OSC_CLOCK), .sub_osc(SUB_OSC_INPUT));

  // Clock generator, 40 ns period
  initial begin
    forever #20 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // Hang guard; the whole run needs under two thousand cycles
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      test_done;
    end
  end

  // Watcher: read data, tick count at interrupt rise, tick count at tone edges, snapshots
  always @(posedge CLK) begin : mon
    logic got;
    logic [31:0] v;
    logic [31:0] e;
    got = 1'b0;
    v = 32'h0;
    tcnt = tcnt + int'(DISP_CLOCK_TICK === 1'b1);
    ncnt = ncnt + int'(DISP_CLOCK_TICK === 1'b1);
    if (zr === 1'b1) begin
      tcnt = 0;
      ncnt = 0;
    end
    if (rd_ph === 1'b1 && HREADYOUT === 1'b1) begin
      got = 1'b1;
      v = HRDATA;
    end else if (snap === 1'b1) begin
      got = 1'b1;
      v = 32'(tcnt);
    end else if (WATCH_IRQ === 1'b1 && irq_q === 1'b0) begin
      got = 1'b1;
      v = 32'(tcnt);
      tcnt = 0;
    end else if (tw === 1'b1 && TONE_OUTPUT !== tone_q) begin
      got = 1'b1;
      v = 32'(ncnt);
      ncnt = 0;
    end
    if (rd_ph === 1'b1 && HRESP !== 1'b0) begin
      fails = fails + 1;
      $display("Error t=%0t resp %h exp %h", $time, HRESP, 1'b0);
    end
    irq_q = WATCH_IRQ;
    tone_q = TONE_OUTPUT;
    if (got) begin
      compares = compares + 1;
      e = (q.size() == 0) ? 32'hdead_0000 : q.pop_front();
      if (v !== e) begin
        fails = fails + 1;
        $display("Error t=%0t got %h exp %h", $time, v, e);
      end
    end
  end

  // One single AHB-Lite transfer: address phase, then data phase
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    HSIZE <= 3'h2;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= d;
    rd_ph <= ~wr;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    rd_ph <= 1'b0;
  endtask : bus

  task rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task mark(input logic sn);
    snap <= sn;
    zr <= ~sn;
    @(posedge CLK);
    snap <= 1'b0;
    zr <= 1'b0;
  endtask : mark

  task wait_done(input string name);
    while (q.size() != 0) @(posedge CLK);
    $display("test %s finished", name);
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    rd(`WT_ADDR_MODE, 32'h8);
    rd(`WT_ADDR_STAT, 32'h0);
    rd(`WT_ADDR_MASK, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rv = $random(seed);
      lvl <= rv[9];
      wr(`WT_ADDR_MODE, rv & 32'hffff_ff7b);
      rd(`WT_ADDR_MODE, {28'h0, rv[9], 3'h0});
    end
    wr(AU, $random(seed));
    rd(AU, 32'h0);
    wait_done("mode access");
    wr(`WT_ADDR_MASK, 32'h1);
    // Sub normal, sub fast, main normal, main fast: two intervals each
    for (int i = 0; i < 4; i++) begin
      wr(`WT_ADDR_MODE, 32'h0);
      wr(`WT_ADDR_STAT, 32'h1);
      sub_on <= tbl[i][0]; // Source bit picks which crystal runs
      main_on <= ~tbl[i][0];
      wr(`WT_ADDR_MODE, {24'h0, tbl[i] | 8'h04});
      mark(1'b0);
      repeat (2) begin
        q.push_back(tbl[i][1] ? 32'd4 : 32'd16);
        while (q.size() != 0) @(posedge CLK);
        wr(`WT_ADDR_STAT, 32'h1);
      end
    end
    wr(`WT_ADDR_MODE, 32'h0);
    mark(1'b0);
    repeat (40) @(posedge CLK);
    q.push_back(32'h0);
    mark(1'b1);
    wait_done("intervals");
    wr(`WT_ADDR_MASK, 32'h0);
    wr(`WT_ADDR_STAT, 32'h1);
    main_on <= 1'b0;
    sub_on <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      tw <= 1'b1;
      wr(`WT_ADDR_MODE, 32'h85 | (s << 4));
      mark(1'b0);
      repeat (2) q.push_back(32'h1 << (3 - s));
      while (q.size() != 0) @(posedge CLK);
      tw <= 1'b0;
      wr(`WT_ADDR_MODE, 32'h0);
    end
    // Tone left disabled: any edge on the pin is an unexpected result
    tw <= 1'b1;
    wr(`WT_ADDR_MODE, 32'h35);
    repeat (60) @(posedge CLK);
    tw <= 1'b0;
    rd(`WT_ADDR_STAT, 32'h1);
    wr(`WT_ADDR_STAT, 32'h1);
    rd(`WT_ADDR_STAT, 32'h0);
    wait_done("tone");
    // Second reset in mid-run with the interrupt up
    wr(`WT_ADDR_MASK, 32'h1);
    wr(`WT_ADDR_MODE, 32'h0);
    wr(`WT_ADDR_MODE, 32'h85);
    mark(1'b0);
    q.push_back(32'd16);
    repeat (200) @(posedge CLK);
    sub_on <= 1'b0;
    lvl <= 1'b0;
    RESET <= 1'b1;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    rd(`WT_ADDR_MODE, 32'h0);
    rd(`WT_ADDR_STAT, 32'h0);
    rd(`WT_ADDR_MASK, 32'h0);
    wait_done("reset in run");
    test_done;
  end
endmodule : tb_top

`default_nettype wire
